// [hw/pivr_pkg.sv]
// Operation
// - Watchdog register bits 14-8 hold interval vector.
// - Watchdog register bits 6-0 hold refresh vector.
// - Receive register bits 14-8 hold error vector.
// - Receive register bits 6-0 hold full vector.
// - Transmit register bits 14-8 hold empty vector.
// - Transmit register bits 6-0 hold end vector.
// - Timer register bits 14-8 hold capture vector.
// - Timer register bits 6-0 hold compare vector.
// - Overflow register bits 14-8; low byte reserved.
// - Reserved bits are read-only and read zero.
// - Fields are plain binary vectors 0 to 127.
// - Any reset clears every vector register.
// - Standby leaves vector registers unchanged.
// - Table entry is base plus four times vector.
// - Registers are 16-bit, software readable and writable.
// - Peripheral vectors come from register fields.
package pivr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths and counts.
	localparam int unsigned PIVR_ADDR_W  = 4;
	localparam int unsigned PIVR_DATA_W  = 16;
	localparam int unsigned PIVR_VEC_W   = 7;
	localparam int unsigned PIVR_BASE_W  = 32;
	localparam int unsigned PIVR_NUM_REG = 5;
	localparam int unsigned PIVR_IDX_W   = 3;
	localparam int unsigned PIVR_VEC_SHIFT = 2;

	////////////////////////////////////////////////////////////////////////
	// Register offsets, byte addresses of 16-bit registers.
	localparam logic [PIVR_ADDR_W-1:0] PIVR_OFS_WDT    = 4'h0;
	localparam logic [PIVR_ADDR_W-1:0] PIVR_OFS_RX     = 4'h2;
	localparam logic [PIVR_ADDR_W-1:0] PIVR_OFS_TX     = 4'h4;
	localparam logic [PIVR_ADDR_W-1:0] PIVR_OFS_TMR_CC = 4'h6;
	localparam logic [PIVR_ADDR_W-1:0] PIVR_OFS_TMR_OV = 4'h8;

	// Register indices; the last one marks an unmapped address.
	localparam logic [PIVR_IDX_W-1:0] PIVR_IDX_WDT    = 3'h0;
	localparam logic [PIVR_IDX_W-1:0] PIVR_IDX_RX     = 3'h1;
	localparam logic [PIVR_IDX_W-1:0] PIVR_IDX_TX     = 3'h2;
	localparam logic [PIVR_IDX_W-1:0] PIVR_IDX_TMR_CC = 3'h3;
	localparam logic [PIVR_IDX_W-1:0] PIVR_IDX_TMR_OV = 3'h4;
	localparam logic [PIVR_IDX_W-1:0] PIVR_IDX_NONE   = 3'h5;

	////////////////////////////////////////////////////////////////////////
	// Field positions, reset value and writable-bit masks.
	localparam int unsigned PIVR_HI_MSB = 14;
	localparam int unsigned PIVR_HI_LSB = 8;
	localparam int unsigned PIVR_LO_MSB = 6;
	localparam int unsigned PIVR_LO_LSB = 0;
	localparam int unsigned PIVR_RSV_HI = 15;
	localparam int unsigned PIVR_RSV_LO = 7;
	localparam logic [PIVR_DATA_W-1:0] PIVR_RESET_VAL = 16'h0000;
	localparam logic [PIVR_DATA_W-1:0] PIVR_MASK_PAIR = 16'h7F7F;
	localparam logic [PIVR_DATA_W-1:0] PIVR_MASK_HI   = 16'h7F00;
	localparam logic [PIVR_DATA_W-1:0] PIVR_REG_MASK [PIVR_NUM_REG] = '{
		PIVR_MASK_PAIR, PIVR_MASK_PAIR, PIVR_MASK_PAIR, PIVR_MASK_PAIR, PIVR_MASK_HI
	};

	////////////////////////////////////////////////////////////////////////
	// Peripheral interrupt sources.
	typedef enum logic [3:0] {
		PIVR_SRC_INTERVAL,
		PIVR_SRC_REFRESH,
		PIVR_SRC_RX_ERROR,
		PIVR_SRC_RX_FULL,
		PIVR_SRC_TX_EMPTY,
		PIVR_SRC_TX_END,
		PIVR_SRC_CAPTURE,
		PIVR_SRC_COMPARE,
		PIVR_SRC_OVERFLOW
	} pivr_src_t;

	// All nine vector fields as held by the registers.
	typedef struct packed {
		logic [PIVR_VEC_W-1:0] watchdog_interval_vector;
		logic [PIVR_VEC_W-1:0] refresh_match_vector;
		logic [PIVR_VEC_W-1:0] serial_rx_error_vector;
		logic [PIVR_VEC_W-1:0] serial_rx_full_vector;
		logic [PIVR_VEC_W-1:0] serial_tx_empty_vector;
		logic [PIVR_VEC_W-1:0] serial_tx_end_vector;
		logic [PIVR_VEC_W-1:0] timer_capture_vector;
		logic [PIVR_VEC_W-1:0] timer_compare_vector;
		logic [PIVR_VEC_W-1:0] timer_overflow_vector_field;
	} pivr_vec_bank_t;

	// Vector answer handed to the core.
	typedef struct packed {
		logic                   valid;
		logic [PIVR_VEC_W-1:0]  num;
		logic [PIVR_BASE_W-1:0] addr;
	} pivr_vec_ans_t;

endpackage

// [hw/pivr_vec_reg.sv]
`timescale 1ns/10ps
module pivr_vec_reg
	import pivr_pkg::*;
#(
	parameter logic [PIVR_DATA_W-1:0] WR_MASK = PIVR_MASK_PAIR
)
(
	// Clock and reset.
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_i,
	// Write side and stored value.
	input  wire logic                   wr_en_i,
	input  wire logic [PIVR_DATA_W-1:0] wdata_i,
	output logic      [PIVR_DATA_W-1:0] q_o
);

	logic [PIVR_DATA_W-1:0] q_d;
	logic [PIVR_DATA_W-1:0] q_q;

	////////////////////////////////////////////////////////////////////////
	// Reserved bits are masked on write, so they can never read back as one
	// even if software ignores the write-zero convention.
	always_comb begin
		q_d = q_q;
		if (wr_en_i) begin
			q_d = wdata_i & WR_MASK;
		end
	end

	// Only the reset clears the register; standby has no path in here.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			q_q <= PIVR_RESET_VAL;
		end else begin
			q_q <= q_d;
		end
	end

	assign q_o = q_q;

endmodule

// [hw/pivr_vec_lookup.sv]
`timescale 1ns/10ps
module pivr_vec_lookup
	import pivr_pkg::*;
(
	// Field bank and selection.
	input  wire pivr_vec_bank_t         bank_i,
	input  wire pivr_src_t              src_i,
	input  wire logic [PIVR_BASE_W-1:0] base_i,
	// Selected vector and its table entry address.
	output logic      [PIVR_VEC_W-1:0]  num_o,
	output logic      [PIVR_BASE_W-1:0] addr_o
);

	////////////////////////////////////////////////////////////////////////
	// Each source reads its own programmed field, never a fixed number.
	always_comb begin
		case (src_i)
			PIVR_SRC_INTERVAL: num_o = bank_i.watchdog_interval_vector;
			PIVR_SRC_REFRESH:  num_o = bank_i.refresh_match_vector;
			PIVR_SRC_RX_ERROR: num_o = bank_i.serial_rx_error_vector;
			PIVR_SRC_RX_FULL:  num_o = bank_i.serial_rx_full_vector;
			PIVR_SRC_TX_EMPTY: num_o = bank_i.serial_tx_empty_vector;
			PIVR_SRC_TX_END:   num_o = bank_i.serial_tx_end_vector;
			PIVR_SRC_CAPTURE:  num_o = bank_i.timer_capture_vector;
			PIVR_SRC_COMPARE:  num_o = bank_i.timer_compare_vector;
			PIVR_SRC_OVERFLOW: num_o = bank_i.timer_overflow_vector_field;
			default:           num_o = '0;
		endcase
	end

	// The vector is plain binary, so scaling by four is a shift; the sum
	// wraps at the top of the address space like the core's adder.
	assign addr_o = base_i + (PIVR_BASE_W'(num_o) << PIVR_VEC_SHIFT);

endmodule

// [hw/pivr_top.sv]
`timescale 1ns/10ps
module pivr_top
	import pivr_pkg::*;
(
	// Clock and reset.
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_i,
	// Register port.
	input  wire logic [PIVR_ADDR_W-1:0] reg_addr_i,
	input  wire logic [PIVR_DATA_W-1:0] reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output logic      [PIVR_DATA_W-1:0] reg_rdata_o,
	// Power state and arbitration winner.
	input  wire logic                   standby_i,
	input  wire logic                   win_valid_i,
	input  wire pivr_src_t              win_src_i,
	input  wire logic [PIVR_BASE_W-1:0] vector_base_i,
	// Vector fields and registered vector answer.
	output pivr_vec_bank_t              vec_bank_o,
	output logic                        vec_valid_o,
	output logic      [PIVR_VEC_W-1:0]  vec_num_o,
	output logic      [PIVR_BASE_W-1:0] vec_addr_o
);

	////////////////////////////////////////////////////////////////////////
	// Address decode, shared by the write and the read path.
	function automatic logic [PIVR_IDX_W-1:0] reg_index(
		input logic [PIVR_ADDR_W-1:0] addr
	);
		logic [PIVR_IDX_W-1:0] idx;
		idx = PIVR_IDX_NONE;
		if (addr == PIVR_OFS_WDT) begin
			idx = PIVR_IDX_WDT;
		end else if (addr == PIVR_OFS_RX) begin
			idx = PIVR_IDX_RX;
		end else if (addr == PIVR_OFS_TX) begin
			idx = PIVR_IDX_TX;
		end else if (addr == PIVR_OFS_TMR_CC) begin
			idx = PIVR_IDX_TMR_CC;
		end else if (addr == PIVR_OFS_TMR_OV) begin
			idx = PIVR_IDX_TMR_OV;
		end
		return idx;
	endfunction

	logic [PIVR_DATA_W-1:0] reg_q [PIVR_NUM_REG];
	logic [PIVR_NUM_REG-1:0] wr_sel;
	logic [PIVR_IDX_W-1:0]  wr_idx;
	logic [PIVR_IDX_W-1:0]  rd_idx;
	logic [PIVR_DATA_W-1:0] rdata_d;
	logic [PIVR_DATA_W-1:0] rdata_q;
	pivr_vec_bank_t         bank;
	pivr_vec_ans_t          ans_d;
	pivr_vec_ans_t          ans_q;
	logic [PIVR_VEC_W-1:0]  look_num;
	logic [PIVR_BASE_W-1:0] look_addr;

	assign wr_idx = reg_index(reg_addr_i);
	assign rd_idx = reg_index(reg_addr_i);

	////////////////////////////////////////////////////////////////////////
	// The five vector registers; a write to an unmapped address hits none.
	for (genvar g = 0; g < PIVR_NUM_REG; g++) begin : g_reg
		assign wr_sel[g] = reg_wr_i && (wr_idx == PIVR_IDX_W'(g));

		pivr_vec_reg #(
			.WR_MASK    (PIVR_REG_MASK[g])
		) u_reg (
			.core_clk_i (core_clk_i),
			.rst_i      (rst_i),
			.wr_en_i    (wr_sel[g]),
			.wdata_i    (reg_wdata_i),
			.q_o        (reg_q[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Field bank taken straight from the register flops.
	always_comb begin
		bank.watchdog_interval_vector    = reg_q[PIVR_IDX_WDT][PIVR_HI_MSB:PIVR_HI_LSB];
		bank.refresh_match_vector        = reg_q[PIVR_IDX_WDT][PIVR_LO_MSB:PIVR_LO_LSB];
		bank.serial_rx_error_vector      = reg_q[PIVR_IDX_RX][PIVR_HI_MSB:PIVR_HI_LSB];
		bank.serial_rx_full_vector       = reg_q[PIVR_IDX_RX][PIVR_LO_MSB:PIVR_LO_LSB];
		bank.serial_tx_empty_vector      = reg_q[PIVR_IDX_TX][PIVR_HI_MSB:PIVR_HI_LSB];
		bank.serial_tx_end_vector        = reg_q[PIVR_IDX_TX][PIVR_LO_MSB:PIVR_LO_LSB];
		bank.timer_capture_vector        = reg_q[PIVR_IDX_TMR_CC][PIVR_HI_MSB:PIVR_HI_LSB];
		bank.timer_compare_vector        = reg_q[PIVR_IDX_TMR_CC][PIVR_LO_MSB:PIVR_LO_LSB];
		bank.timer_overflow_vector_field = reg_q[PIVR_IDX_TMR_OV][PIVR_HI_MSB:PIVR_HI_LSB];
	end

	// The core can use the winner's field in the very cycle of its request.
	assign vec_bank_o = bank;

	////////////////////////////////////////////////////////////////////////
	// Read path: data stands one cycle after the strobe and reads zero
	// otherwise, which also serves as the answer to unmapped addresses.
	always_comb begin
		rdata_d = '0;
		if (reg_rd_i && (rd_idx != PIVR_IDX_NONE)) begin
			rdata_d = reg_q[rd_idx];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Vector lookup for the winning source.
	pivr_vec_lookup u_lookup (
		.bank_i  (bank),
		.src_i   (win_src_i),
		.base_i  (vector_base_i),
		.num_o   (look_num),
		.addr_o  (look_addr)
	);

	// No answer is formed in standby because the peripherals are halted;
	// the registered copy costs a cycle but keeps the outputs glitch free.
	always_comb begin
		ans_d = '0;
		if (win_valid_i && !standby_i) begin
			ans_d.valid = 1'b1;
			ans_d.num   = look_num;
			ans_d.addr  = look_addr;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ans_q <= '0;
		end else begin
			ans_q <= ans_d;
		end
	end

	assign vec_valid_o = ans_q.valid;
	assign vec_num_o   = ans_q.num;
	assign vec_addr_o  = ans_q.addr;

	////////////////////////////////////////////////////////////////////////
	// Checks on the register file and the vector answer.
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	a_wdt_hi_field: assert property (
		reg_wr_i && reg_addr_i == PIVR_OFS_WDT
		|=> vec_bank_o.watchdog_interval_vector == $past(reg_wdata_i[PIVR_HI_MSB:PIVR_HI_LSB])
	) else $error("Interval vector did not take the written value.");

	a_wdt_lo_field: assert property (
		reg_wr_i && reg_addr_i == PIVR_OFS_WDT
		|=> vec_bank_o.refresh_match_vector == $past(reg_wdata_i[PIVR_LO_MSB:PIVR_LO_LSB])
	) else $error("Refresh vector did not take the written value.");

	a_rx_hi_field: assert property (
		reg_wr_i && reg_addr_i == PIVR_OFS_RX
		|=> vec_bank_o.serial_rx_error_vector == $past(reg_wdata_i[PIVR_HI_MSB:PIVR_HI_LSB])
	) else $error("Receive error vector did not take the written value.");

	a_rx_lo_field: assert property (
		reg_wr_i && reg_addr_i == PIVR_OFS_RX
		|=> vec_bank_o.serial_rx_full_vector == $past(reg_wdata_i[PIVR_LO_MSB:PIVR_LO_LSB])
	) else $error("Receive full vector did not take the written value.");

	a_tx_hi_field: assert property (
		reg_wr_i && reg_addr_i == PIVR_OFS_TX
		|=> vec_bank_o.serial_tx_empty_vector == $past(reg_wdata_i[PIVR_HI_MSB:PIVR_HI_LSB])
	) else $error("Transmit empty vector did not take the written value.");

	a_tx_lo_field: assert property (
		reg_wr_i && reg_addr_i == PIVR_OFS_TX
		|=> vec_bank_o.serial_tx_end_vector == $past(reg_wdata_i[PIVR_LO_MSB:PIVR_LO_LSB])
	) else $error("Transmit end vector did not take the written value.");

	a_cc_hi_field: assert property (
		reg_wr_i && reg_addr_i == PIVR_OFS_TMR_CC
		|=> vec_bank_o.timer_capture_vector == $past(reg_wdata_i[PIVR_HI_MSB:PIVR_HI_LSB])
	) else $error("Capture vector did not take the written value.");

	a_cc_lo_field: assert property (
		reg_wr_i && reg_addr_i == PIVR_OFS_TMR_CC
		|=> vec_bank_o.timer_compare_vector == $past(reg_wdata_i[PIVR_LO_MSB:PIVR_LO_LSB])
	) else $error("Compare vector did not take the written value.");

	a_ov_low_byte: assert property (
		reg_wr_i && reg_addr_i == PIVR_OFS_TMR_OV ##1 reg_rd_i && reg_addr_i == PIVR_OFS_TMR_OV
		|=> reg_rdata_o == {1'b0, $past(reg_wdata_i[PIVR_HI_MSB:PIVR_HI_LSB], 2), 8'h00}
	) else $error("Overflow register read back wrong or low byte not zero.");

	a_rsv_read_zero: assert property (
		!reg_rdata_o[PIVR_RSV_HI] && !reg_rdata_o[PIVR_RSV_LO]
	) else $error("A reserved bit read as one.");

	a_vec_plain_bin: assert property (
		win_valid_i && !standby_i && win_src_i == PIVR_SRC_OVERFLOW
		|=> vec_num_o == $past(vec_bank_o.timer_overflow_vector_field)
		&& vec_addr_o - $past(vector_base_i) == PIVR_BASE_W'(vec_num_o) * 4
	) else $error("Overflow vector number not passed as plain binary.");

	property p_reset_clear;
		@(posedge core_clk_i) disable iff (1'b0)
		rst_i |=> vec_bank_o == '0 && reg_rdata_o == '0 && !vec_valid_o;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("Reset did not clear the vector registers.");

	a_standby_hold: assert property (
		standby_i && !reg_wr_i |=> $stable(vec_bank_o)
	) else $error("Vector fields changed in standby without a write.");

	a_table_addr: assert property (
		vec_valid_o |-> vec_addr_o == $past(vector_base_i) + PIVR_BASE_W'({vec_num_o, 2'b00})
	) else $error("Vector table address is not base plus four times vector.");

	sequence s_write_then_read;
		reg_wr_i && reg_addr_i == PIVR_OFS_RX ##1 reg_rd_i && reg_addr_i == PIVR_OFS_RX;
	endsequence
	a_rw_16bit: assert property (
		s_write_then_read |=> reg_rdata_o == ($past(reg_wdata_i, 2) & PIVR_MASK_PAIR)
	) else $error("Register did not read back the written 16-bit value.");

	a_field_source: assert property (
		win_valid_i && !standby_i && win_src_i == PIVR_SRC_INTERVAL
		|=> vec_num_o == $past(vec_bank_o.watchdog_interval_vector)
	) else $error("Interval request did not use its programmed vector.");

	a_answer_time: assert property (
		win_valid_i && !standby_i
		|=> vec_valid_o ##1 (vec_valid_o == $past(win_valid_i && !standby_i))
	) else $error("Vector answer missing or stretched.");

	a_idle_no_ans: assert property (
		!(win_valid_i && !standby_i) |=> !vec_valid_o && vec_num_o == '0
	) else $error("Vector answer without a winning request.");

	a_rd_one_cycle: assert property (
		!reg_rd_i |=> reg_rdata_o == '0
	) else $error("Read data stood outside the cycle after the strobe.");

	// Every source must reach its own field; a swapped pair of fields would
	// still satisfy the table-address check, so the seven sources not pinned above are pinned here.
	a_refresh_src: assert property (
		win_valid_i && !standby_i && win_src_i == PIVR_SRC_REFRESH
		|=> vec_num_o == $past(vec_bank_o.refresh_match_vector)
	) else $error("Refresh source used a wrong vector.");

	a_rx_error_src: assert property (
		win_valid_i && !standby_i && win_src_i == PIVR_SRC_RX_ERROR
		|=> vec_num_o == $past(vec_bank_o.serial_rx_error_vector)
	) else $error("Receive error source used a wrong vector.");

	a_rx_full_src: assert property (
		win_valid_i && !standby_i && win_src_i == PIVR_SRC_RX_FULL
		|=> vec_num_o == $past(vec_bank_o.serial_rx_full_vector)
	) else $error("Receive full source used a wrong vector.");

	a_tx_empty_src: assert property (
		win_valid_i && !standby_i && win_src_i == PIVR_SRC_TX_EMPTY
		|=> vec_num_o == $past(vec_bank_o.serial_tx_empty_vector)
	) else $error("Transmit empty source used a wrong vector.");

	a_tx_end_src: assert property (
		win_valid_i && !standby_i && win_src_i == PIVR_SRC_TX_END
		|=> vec_num_o == $past(vec_bank_o.serial_tx_end_vector)
	) else $error("Transmit end source used a wrong vector.");

	a_capture_src: assert property (
		win_valid_i && !standby_i && win_src_i == PIVR_SRC_CAPTURE
		|=> vec_num_o == $past(vec_bank_o.timer_capture_vector)
	) else $error("Capture source used a wrong vector.");

	a_compare_src: assert property (
		win_valid_i && !standby_i && win_src_i == PIVR_SRC_COMPARE
		|=> vec_num_o == $past(vec_bank_o.timer_compare_vector)
	) else $error("Compare source used a wrong vector.");

	// Read data must be the register as it stood at the strobe, with the
	// reserved positions forced to zero.
	a_rd_wdt_data: assert property (
		reg_rd_i && reg_addr_i == PIVR_OFS_WDT
		|=> reg_rdata_o == {1'b0, $past(vec_bank_o.watchdog_interval_vector),
			1'b0, $past(vec_bank_o.refresh_match_vector)}
	) else $error("Watchdog register read back wrong data.");

	a_rd_rx_data: assert property (
		reg_rd_i && reg_addr_i == PIVR_OFS_RX
		|=> reg_rdata_o == {1'b0, $past(vec_bank_o.serial_rx_error_vector),
			1'b0, $past(vec_bank_o.serial_rx_full_vector)}
	) else $error("Receive register read back wrong data.");

	a_rd_tx_data: assert property (
		reg_rd_i && reg_addr_i == PIVR_OFS_TX
		|=> reg_rdata_o == {1'b0, $past(vec_bank_o.serial_tx_empty_vector),
			1'b0, $past(vec_bank_o.serial_tx_end_vector)}
	) else $error("Transmit register read back wrong data.");

	a_rd_cc_data: assert property (
		reg_rd_i && reg_addr_i == PIVR_OFS_TMR_CC
		|=> reg_rdata_o == {1'b0, $past(vec_bank_o.timer_capture_vector),
			1'b0, $past(vec_bank_o.timer_compare_vector)}
	) else $error("Timer register read back wrong data.");

	a_rd_ov_data: assert property (
		reg_rd_i && reg_addr_i == PIVR_OFS_TMR_OV
		|=> reg_rdata_o == {1'b0, $past(vec_bank_o.timer_overflow_vector_field), 8'h00}
	) else $error("Overflow register read back wrong data.");

	// An unmapped address must neither disturb a field nor return data.
	a_unmapped_wr: assert property (
		reg_wr_i && reg_index(reg_addr_i) == PIVR_IDX_NONE |=> $stable(vec_bank_o)
	) else $error("Unmapped write changed a vector field.");

	a_unmapped_rd: assert property (
		reg_rd_i && reg_index(reg_addr_i) == PIVR_IDX_NONE |=> reg_rdata_o == '0
	) else $error("Unmapped read returned data.");

	// Fields move only on a write or a reset, whatever the power state does.
	a_no_wr_hold: assert property (
		!reg_wr_i |=> $stable(vec_bank_o)
	) else $error("A vector field changed without a write.");

	// The answer exists only for an accepted request and is zero otherwise.
	a_ans_needs_req: assert property (
		vec_valid_o |-> $past(win_valid_i && !standby_i)
	) else $error("Vector answer without an accepted request.");

	a_standby_no_ans: assert property (
		standby_i |=> !vec_valid_o
	) else $error("Vector answer given during standby.");

	a_idle_addr_zero: assert property (
		!vec_valid_o |-> vec_addr_o == '0
	) else $error("Vector address stood without a valid answer.");

	c_write_read: cover property (s_write_then_read);
	c_max_vector: cover property (vec_valid_o && vec_num_o == 7'h7F);
	c_standby_win: cover property (win_valid_i && standby_i);
	c_back_to_back: cover property (vec_valid_o [*3]);
	c_unmapped_rd: cover property (reg_rd_i && reg_index(reg_addr_i) == PIVR_IDX_NONE);

endmodule

// [tb/pivr_core_model.sv]
`timescale 1ns/10ps
module pivr_core_model
	import pivr_pkg::*;
(
	// Clock.
	input  wire logic                   core_clk_i,
	// Registered vector answer from the block.
	input  wire logic                   vec_valid_i,
	input  wire logic [PIVR_VEC_W-1:0]  vec_num_i,
	input  wire logic [PIVR_BASE_W-1:0] vec_addr_i,
	// Arbitration winner towards the block.
	output logic                        win_valid_o,
	output pivr_src_t                   win_src_o,
	output logic      [PIVR_BASE_W-1:0] vector_base_o
);

	////////////////////////////////////////////////////////////////////////
	// Idle values at time zero, before the first win is presented.
	initial begin
		win_valid_o   = 1'b0;
		win_src_o     = PIVR_SRC_INTERVAL;
		vector_base_o = 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// One accepted interrupt: the winner is held for one taken edge, and the answer is
	// sampled at the edge that closes the cycle after it. A lag makes the core slow.
	// The block forms the table entry from the base; the core only samples vec_addr_i.
	task automatic take_irq(
		input  pivr_src_t                   src,
		input  logic      [PIVR_BASE_W-1:0] base,
		input  int unsigned                 lag,
		output logic                        got_valid,
		output logic      [PIVR_VEC_W-1:0]  got_num,
		output logic      [PIVR_BASE_W-1:0] got_addr
	);
		repeat (lag) @(posedge core_clk_i);
		win_valid_o   <= 1'b1;
		win_src_o     <= src;
		vector_base_o <= base;
		@(posedge core_clk_i);
		// Base is not frozen afterwards, so a design that samples it late is caught.
		win_valid_o   <= 1'b0;
		vector_base_o <= ~base;
		@(posedge core_clk_i);
		got_valid = vec_valid_i;
		got_num   = vec_num_i;
		got_addr  = vec_addr_i;
	endtask

endmodule

// [tb/pivr_top_tb_top.sv]
`timescale 1ns/10ps
module pivr_top_tb_top;
	import pivr_pkg::*;

	logic                   core_clk;
	logic                   rst;
	logic [PIVR_ADDR_W-1:0] reg_addr;
	logic [PIVR_DATA_W-1:0] reg_wdata;
	logic                   reg_wr;
	logic                   reg_rd;
	logic [PIVR_DATA_W-1:0] reg_rdata;
	logic                   standby;
	logic                   win_valid;
	pivr_src_t              win_src;
	logic [PIVR_BASE_W-1:0] vector_base;
	pivr_vec_bank_t         vec_bank;
	logic                   vec_valid;
	logic [PIVR_VEC_W-1:0]  vec_num;
	logic [PIVR_BASE_W-1:0] vec_addr;
	int                     fails;
	int                     samples_checked;

	pivr_top dut_u (
		.core_clk_i    (core_clk),
		.rst_i         (rst),
		.reg_addr_i    (reg_addr),
		.reg_wdata_i   (reg_wdata),
		.reg_wr_i      (reg_wr),
		.reg_rd_i      (reg_rd),
		.reg_rdata_o   (reg_rdata),
		.standby_i     (standby),
		.win_valid_i   (win_valid),
		.win_src_i     (win_src),
		.vector_base_i (vector_base),
		.vec_bank_o    (vec_bank),
		.vec_valid_o   (vec_valid),
		.vec_num_o     (vec_num),
		.vec_addr_o    (vec_addr)
	);

	pivr_core_model core_u (
		.core_clk_i    (core_clk),
		.vec_valid_i   (vec_valid),
		.vec_num_i     (vec_num),
		.vec_addr_i    (vec_addr),
		.win_valid_o   (win_valid),
		.win_src_o     (win_src),
		.vector_base_o (vector_base)
	);

	////////////////////////////////////////////////////////////////////////
	// 200 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Compare, count and report.
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		if (fails == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Register access; each task leaves one idle cycle so no strobe is driven twice at an edge.
	task automatic reg_write(input logic [PIVR_ADDR_W-1:0] a, input logic [PIVR_DATA_W-1:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic reg_read(input logic [PIVR_ADDR_W-1:0] a, output logic [PIVR_DATA_W-1:0] d);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask

	// Write and read of one register with no gap between the strobes.
	task automatic reg_wr_rd(input logic [PIVR_ADDR_W-1:0] a, input logic [PIVR_DATA_W-1:0] d,
		output logic [PIVR_DATA_W-1:0] q);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		q = reg_rdata;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Register map as the bench sees it, and the values written in the field tests.
	logic [PIVR_ADDR_W-1:0] ofs  [5] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8};
	logic [PIVR_DATA_W-1:0] mask [5] = '{16'h7F7F, 16'h7F7F, 16'h7F7F, 16'h7F7F, 16'h7F00};
	logic [PIVR_DATA_W-1:0] vals [5] = '{16'h0A7F, 16'h7F00, 16'h1122, 16'h3344, 16'h5500};

	// Field of source s: even sources sit in bits 14..8, odd ones in bits 6..0.
	function automatic logic [6:0] fld(input int s);
		return (s % 2 == 0) ? vals[s/2][14:8] : vals[s/2][6:0];
	endfunction

	logic [PIVR_DATA_W-1:0] rd;
	logic [62:0]            exp_bank;
	logic                   got_v;
	logic [PIVR_VEC_W-1:0]  got_n;
	logic [PIVR_BASE_W-1:0] got_a;
	logic [PIVR_BASE_W-1:0] base;

	initial begin
		fails = 0;
		samples_checked = 0;
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		standby = 1'b0;
		base = 32'hFFFF_FF00;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		// Every register starts cleared.
		for (int i = 0; i < 5; i++) begin
			reg_read(ofs[i], rd);
			check(rd, 16'h0000);
		end
		check(vec_bank, 63'h0);
		// All ones written: only the field bits stick, reserved bits read zero.
		for (int i = 0; i < 5; i++) begin
			reg_write(ofs[i], 16'hFFFF);
			reg_read(ofs[i], rd);
			check(rd, mask[i]);
		end
		// Distinct values with reserved bits zero, 0 and 127 in one word, read with no gap.
		for (int i = 0; i < 5; i++) begin
			reg_wr_rd(ofs[i], vals[i], rd);
			check(rd, vals[i]);
		end
		exp_bank = '0;
		for (int s = 0; s < 9; s++) exp_bank = {exp_bank[55:0], fld(s)};
		check(vec_bank, exp_bank);
		// Unmapped address: write dropped, read gives zero.
		reg_write(4'hA, 16'h7F7F);
		reg_read(4'hA, rd);
		check(rd, 16'h0000);
		check(vec_bank, exp_bank);
		// Every source, prompt and slow core, base near the top so the sum wraps.
		for (int s = 0; s < 9; s++) begin
			core_u.take_irq(pivr_src_t'(s), base, s % 2, got_v, got_n, got_a);
			check(got_v, 1'b1);
			check(got_n, fld(s));
			check(got_a, PIVR_BASE_W'(base + {fld(s), 2'b00}));
			// The answer stands one cycle; look after the edge that drops it.
			@(posedge core_clk);
			check(vec_valid, 1'b0);
		end
		// Standby: no answer, contents kept, writes still land.
		standby <= 1'b1;
		reg_write(ofs[0], 16'h2233);
		core_u.take_irq(PIVR_SRC_RX_FULL, base, 0, got_v, got_n, got_a);
		check(got_v, 1'b0);
		standby <= 1'b0;
		reg_read(ofs[1], rd);
		check(rd, vals[1]);
		reg_read(ofs[0], rd);
		check(rd, 16'h2233);
		core_u.take_irq(PIVR_SRC_REFRESH, 32'h0000_0400, 0, got_v, got_n, got_a);
		check(got_n, 7'h33);
		check(got_a, 32'h0000_04CC);
		// Second reset in mid run clears everything again.
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 5; i++) begin
			reg_read(ofs[i], rd);
			check(rd, 16'h0000);
		end
		check(vec_bank, 63'h0);
		end_of_test();
	end

endmodule
